// ===== rtl/pdo_mapper.v
// Process-data message layer of a valve positioner on a CANopen network.
// Assumes a CAN controller below that hands over whole received frames
// and drains whole transmit frames; all inputs are synchronous to clk_in.
//
// Notes on behaviour
// - One fast message each way per frame.
// - Slow messages spaced on a 2 ms tick.
// - SDO parameter writes refused; only PDOs write.
// - Fast status: position, current, six status bits.
// - Temperature/current and two voltages as floats.
// - Error flag words 0-3 in one message.
// - Error flag words 4, 5, 13; tail unused.
// - Error flag words 8, 9, 10; tail unused.
// - Fast demand: position, command bytes 1, 2.
// - Tracking alarm and shutdown error limits.
// - Resolver alarm and shutdown error limits.
// - Tracking alarm and shutdown times, uint16.
// - Motor position-error alarm and shutdown limits.
// - Shaft position-error alarm and shutdown limits.
// - Motor and shaft alarm/shutdown times.
// - Identifier is base plus node number, SYNC excepted.
// - Difference mode: minimum, maximum or average.
// - Fast status sent only after SYNC.
// - Two-byte fields low byte first.
`timescale 1ns/10ps
`include "pdo_map.vh"

module pdo_mapper #(
	parameter SLOW_TICK_CYCLES = `SLOW_SPACING_US * `CLK_MHZ,
	parameter TICK_CW = 19,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	// Clock and reset.
	input wire clk_in,
	input wire nrst_in,
	// Node number.
	input wire [6:0] node_id_in,
	// Received frames.
	input wire rx_valid_in,
	input wire [10:0] rx_id_in,
	input wire [3:0] rx_dlc_in,
	input wire [63:0] rx_data_in,
	output wire rx_ready_out,
	// SDO write requests aimed at parameter objects.
	input wire sdo_wr_in,
	output reg sdo_refuse_out,
	// Valve state to report.
	input wire [15:0] act_pos_in,
	input wire [15:0] act_cur_in,
	input wire [5:0] status_bits_in,
	input wire [31:0] drv_temp_in,
	input wire [31:0] drv_icur_in,
	input wire [31:0] volt1_in,
	input wire [31:0] volt2_in,
	input wire [223:0] err_flags_in,
	// Transmit frames.
	output wire tx_valid_out,
	output wire [10:0] tx_id_out,
	output wire [3:0] tx_dlc_out,
	output wire [63:0] tx_data_out,
	input wire tx_ready_in,
	// Applied fast demand.
	output reg [15:0] pos_demand_out,
	output reg [7:0] cmd1_out,
	output reg auto_detect_out,
	output reg sync_seen_out,
	// Received slow parameters.
	output reg [31:0] trk_alarm_lim_out,
	output reg [31:0] trk_shut_lim_out,
	output reg [31:0] res_alarm_lim_out,
	output reg [31:0] res_shut_lim_out,
	output reg [15:0] trk_alarm_time_out,
	output reg [15:0] trk_shut_time_out,
	output reg [1:0] diff_mode_out,
	output reg [31:0] mot_alarm_lim_out,
	output reg [31:0] mot_shut_lim_out,
	output reg [31:0] shf_alarm_lim_out,
	output reg [31:0] shf_shut_lim_out,
	output reg [15:0] mot_alarm_time_out,
	output reg [15:0] mot_shut_time_out,
	output reg [15:0] shf_alarm_time_out,
	output reg [15:0] shf_shut_time_out
);

	localparam FW = 79;

	// ============================================================
	// Identifier match.
	wire [10:0] node_ext;
	wire hit_sync, hit_fast, hit_trk_lim, hit_res_lim, hit_trk_time;
	wire hit_dmode, hit_mot_lim, hit_shf_lim, hit_pe_time, rx_take;

	// The controller below buffers frames, so reception never stalls.
	assign rx_ready_out = 1'b1;
	assign rx_take = rx_valid_in;
	assign node_ext = {4'h0, node_id_in};

	// Each message but SYNC answers only at its base plus this node number; SYNC uses ID_SYNC alone.
	assign hit_sync = rx_take && rx_id_in == `ID_SYNC;
	assign hit_fast = rx_take &&
		rx_id_in == `ID_RX_FAST + node_ext &&
		(rx_dlc_in == `DLC_RX_FAST_MIN ||
		rx_dlc_in == `DLC_RX_FAST_MAX);
	assign hit_trk_lim = rx_take && rx_dlc_in == `DLC_SLOW &&
		rx_id_in == `ID_RX_TRK_LIM + node_ext;
	assign hit_res_lim = rx_take && rx_dlc_in == `DLC_SLOW &&
		rx_id_in == `ID_RX_RES_LIM + node_ext;
	assign hit_trk_time = rx_take && rx_dlc_in == `DLC_RX_TRK_TIME &&
		rx_id_in == `ID_RX_TRK_TIME + node_ext;
	assign hit_dmode = rx_take && rx_dlc_in == `DLC_RX_DIFF_MODE &&
		rx_id_in == `ID_RX_DIFF_MODE + node_ext;
	assign hit_mot_lim = rx_take && rx_dlc_in == `DLC_SLOW &&
		rx_id_in == `ID_RX_MOT_LIM + node_ext;
	assign hit_shf_lim = rx_take && rx_dlc_in == `DLC_SLOW &&
		rx_id_in == `ID_RX_SHF_LIM + node_ext;
	assign hit_pe_time = rx_take && rx_dlc_in == `DLC_SLOW &&
		rx_id_in == `ID_RX_PE_TIME + node_ext;

	// ============================================================
	// Fast demand: held aside, applied only when SYNC arrives.
	reg [15:0] dem_pos_q;
	reg [7:0] dem_cmd1_q;
	reg dem_cmd2_q;

	// A three-byte demand keeps the previous command byte 2.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dem_pos_q <= `RST_WORD16;
			dem_cmd1_q <= 8'h00;
			dem_cmd2_q <= 1'b0;
		end else if (hit_fast) begin
			dem_pos_q <= rx_data_in[15:0];
			dem_cmd1_q <= rx_data_in[23:16];
			if (rx_dlc_in == `DLC_RX_FAST_MAX) begin
				dem_cmd2_q <= rx_data_in[24 + `CMD2_AUTO_DETECT_BIT];
			end
		end
	end

	// SYNC closes the frame; the held demand becomes the live one.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pos_demand_out <= `RST_WORD16;
			cmd1_out <= 8'h00;
			auto_detect_out <= 1'b0;
			sync_seen_out <= 1'b0;
		end else begin
			sync_seen_out <= hit_sync;
			if (hit_sync) begin
				pos_demand_out <= dem_pos_q;
				cmd1_out <= dem_cmd1_q;
				auto_detect_out <= dem_cmd2_q;
			end
		end
	end

	// ============================================================
	// Slow parameter capture, all fields low byte first.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trk_alarm_lim_out <= `RST_WORD32;
			trk_shut_lim_out <= `RST_WORD32;
			res_alarm_lim_out <= `RST_WORD32;
			res_shut_lim_out <= `RST_WORD32;
			trk_alarm_time_out <= `RST_WORD16;
			trk_shut_time_out <= `RST_WORD16;
			mot_alarm_lim_out <= `RST_WORD32;
			mot_shut_lim_out <= `RST_WORD32;
			shf_alarm_lim_out <= `RST_WORD32;
			shf_shut_lim_out <= `RST_WORD32;
			mot_alarm_time_out <= `RST_WORD16;
			mot_shut_time_out <= `RST_WORD16;
			shf_alarm_time_out <= `RST_WORD16;
			shf_shut_time_out <= `RST_WORD16;
		end else begin
			if (hit_trk_lim) begin
				trk_alarm_lim_out <= rx_data_in[31:0];
				trk_shut_lim_out <= rx_data_in[63:32];
			end
			if (hit_res_lim) begin
				res_alarm_lim_out <= rx_data_in[31:0];
				res_shut_lim_out <= rx_data_in[63:32];
			end
			if (hit_trk_time) begin
				trk_alarm_time_out <= rx_data_in[15:0];
				trk_shut_time_out <= rx_data_in[31:16];
			end
			if (hit_mot_lim) begin
				mot_alarm_lim_out <= rx_data_in[31:0];
				mot_shut_lim_out <= rx_data_in[63:32];
			end
			if (hit_shf_lim) begin
				shf_alarm_lim_out <= rx_data_in[31:0];
				shf_shut_lim_out <= rx_data_in[63:32];
			end
			if (hit_pe_time) begin
				mot_alarm_time_out <= rx_data_in[15:0];
				mot_shut_time_out <= rx_data_in[31:16];
				shf_alarm_time_out <= rx_data_in[47:32];
				shf_shut_time_out <= rx_data_in[63:48];
			end
		end
	end

	// An unknown mode code is dropped so the valve keeps a sane mode.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			diff_mode_out <= `RST_DMODE;
		end else if (hit_dmode) begin
			case (rx_data_in[15:0])
				`DMODE_MIN: diff_mode_out <= 2'h0;
				`DMODE_MAX: diff_mode_out <= 2'h1;
				`DMODE_AVG: diff_mode_out <= 2'h2;
				default: diff_mode_out <= diff_mode_out;
			endcase
		end
	end

	// ============================================================
	// SDO writes to parameter objects are always refused.
	// The master waits for this answer before its next SDO request.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sdo_refuse_out <= 1'b0;
		end else begin
			sdo_refuse_out <= sdo_wr_in;
		end
	end

	// ============================================================
	// Slow transmit sequencer.
	localparam [2:0] SLOW_LAST = 3'd`SLOW_COUNT - 3'd1;
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;
	reg [2:0] slow_idx_q;
	reg state_q, slow_pend_q, fast_pend_q;
	wire tick, start_slow, push_fast, push_slow, fifo_ready;

	// The first tracking-limit message opens the slow reply sequence.
	assign start_slow = hit_trk_lim && state_q == ST_IDLE;

	pdo_tick #(.CYCLES(SLOW_TICK_CYCLES), .CW(TICK_CW)) u_tick (
		.clk_in(clk_in), .nrst_in(nrst_in),
		.restart_in(start_slow),
		.tick_out(tick)
	);

	// One slow message goes out at start and then one per tick.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= ST_IDLE;
			slow_idx_q <= 3'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_slow) begin
						state_q <= ST_RUN;
						slow_idx_q <= 3'h0;
					end
				end
				ST_RUN: begin
					if (push_slow) begin
						if (slow_idx_q == SLOW_LAST) begin
							state_q <= ST_IDLE;
						end else begin
							slow_idx_q <= slow_idx_q + 3'h1;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Pending flags: a new request wins over the clear of the old one.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			slow_pend_q <= 1'b0;
			fast_pend_q <= 1'b0;
		end else begin
			if (start_slow || (state_q == ST_RUN && tick)) begin
				slow_pend_q <= 1'b1;
			end else if (push_slow) begin
				slow_pend_q <= 1'b0;
			end
			if (hit_sync) begin
				fast_pend_q <= 1'b1;
			end else if (push_fast) begin
				fast_pend_q <= 1'b0;
			end
		end
	end

	// Fast status takes priority; a full FIFO stalls both senders.
	assign push_fast = fast_pend_q & fifo_ready;
	assign push_slow = slow_pend_q & ~fast_pend_q & fifo_ready &
		(state_q == ST_RUN);

	// ============================================================
	// Transmit frame assembly.
	reg [10:0] slow_id;
	reg [63:0] slow_data;
	wire [63:0] fast_data;
	wire [FW-1:0] push_word, pop_word;

	// Byte 4 carries six status bits; the upper two read as zero.
	assign fast_data = {24'h000000, 2'h0,
		status_bits_in[`STATUS_USED_BITS-1:0],
		act_cur_in, act_pos_in};

	// Flag word n is err_flags_in[16n+15:16n]; index 0 takes the default.
	always @* begin
		case (slow_idx_q)
			3'h1: begin
				slow_id = `ID_TX_VOLT + node_ext;
				slow_data = {volt2_in, volt1_in};
			end
			3'h2: begin
				slow_id = `ID_TX_ERR_A + node_ext;
				slow_data = err_flags_in[63:0];
			end
			3'h3: begin
				slow_id = `ID_TX_ERR_B + node_ext;
				slow_data = {16'h0000, err_flags_in[223:208],
					err_flags_in[95:64]};
			end
			3'h4: begin
				slow_id = `ID_TX_ERR_C + node_ext;
				slow_data = {16'h0000, err_flags_in[175:128]};
			end
			default: begin
				slow_id = `ID_TX_TEMP + node_ext;
				slow_data = {drv_icur_in, drv_temp_in};
			end
		endcase
	end

	assign push_word = push_fast ?
		{`ID_TX_FAST + node_ext, `DLC_TX_FAST, fast_data} :
		{slow_id, `DLC_SLOW, slow_data};

	pdo_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.clk_in(clk_in), .nrst_in(nrst_in),
		.in_valid_in(push_fast | push_slow),
		.in_data_in(push_word),
		.in_ready_out(fifo_ready),
		.out_valid_out(tx_valid_out),
		.out_data_out(pop_word),
		.out_ready_in(tx_ready_in)
	);

	assign tx_id_out = pop_word[78:68];
	assign tx_dlc_out = pop_word[67:64];
	assign tx_data_out = pop_word[63:0];

endmodule // pdo_mapper

// ===== rtl/pdo_map.vh
// Message map constants for the process-data layer of the valve positioner.
// Assumes 11-bit CAN identifiers and data bytes packed byte 0 in bits [7:0].
`ifndef PDO_MAP_VH
`define PDO_MAP_VH

// ============================================================
// Identifier bases; the node number is added to each one except ID_SYNC.
`define ID_SYNC 11'h080
`define ID_TX_FAST 11'h180
`define ID_TX_TEMP 11'h280
`define ID_TX_VOLT 11'h380
`define ID_TX_ERR_A 11'h2E0
`define ID_TX_ERR_B 11'h3E0
`define ID_TX_ERR_C 11'h4E0
`define ID_RX_FAST 11'h200
`define ID_RX_TRK_LIM 11'h300
`define ID_RX_RES_LIM 11'h400
`define ID_RX_TRK_TIME 11'h500
`define ID_RX_DIFF_MODE 11'h260
`define ID_RX_MOT_LIM 11'h360
`define ID_RX_SHF_LIM 11'h460
`define ID_RX_PE_TIME 11'h560

// ============================================================
// Data lengths in bytes.
`define DLC_TX_FAST 4'h5
`define DLC_SLOW 4'h8
`define DLC_RX_FAST_MIN 4'h3
`define DLC_RX_FAST_MAX 4'h4
`define DLC_RX_TRK_TIME 4'h4
`define DLC_RX_DIFF_MODE 4'h2

// ============================================================
// Field positions inside the 64-bit data word.
`define STATUS_USED_BITS 6
`define CMD2_AUTO_DETECT_BIT 0

// ============================================================
// Resolver difference mode codes.
`define DMODE_MIN 16'h0000
`define DMODE_MAX 16'h0001
`define DMODE_AVG 16'h0002

// ============================================================
// Reset values of received parameters.
`define RST_WORD16 16'h0000
`define RST_WORD32 32'h00000000
`define RST_DMODE 2'h0

// ============================================================
// Timing: slow message spacing and clock rate.
`define SLOW_SPACING_US 2000
`define CLK_MHZ 200
`define SLOW_COUNT 5

`endif

// ===== rtl/pdo_fifo.v
// Synchronous FIFO for outgoing message words.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/10ps

module pdo_fifo #(
	parameter WIDTH = 79,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire clk_in,
	input wire nrst_in,
	// Filling side.
	input wire in_valid_in,
	input wire [WIDTH-1:0] in_data_in,
	output wire in_ready_out,
	// Draining side.
	output wire out_valid_out,
	output wire [WIDTH-1:0] out_data_out,
	input wire out_ready_in
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready_out = (cnt_q != DEPTH[AW:0]);
	assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
	assign out_data_out = mem_q[rd_q];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	// Storage has no reset; only entries below the count are ever read.
	always @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	// Pointers wrap because the depth is a power of two.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // pdo_fifo

// ===== rtl/pdo_tick.v
// Free counter giving one pulse every CYCLES clocks, restartable.
// Assumes one clock; restart realigns the phase to the current cycle.
`timescale 1ns/10ps

module pdo_tick #(
	parameter CYCLES = 400000,
	parameter CW = 19
) (
	// Clock and reset.
	input wire clk_in,
	input wire nrst_in,
	// Control and pulse.
	input wire restart_in,
	output wire tick_out
);

	localparam integer LAST_I = CYCLES - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];
	reg [CW-1:0] cnt_q;

	assign tick_out = (cnt_q == LAST) & ~restart_in;

	// Restart wins so the first spacing is a full period.
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= {CW{1'b0}};
		end else if (restart_in || cnt_q == LAST) begin
			cnt_q <= {CW{1'b0}};
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule // pdo_tick

// ===== sim/pdo_mapper_asserts.sv
// Checker for the process-data layer, watching the top module's ports.
// Assumes node_id_in holds steady while traffic runs.
`timescale 1ns/10ps
`include "pdo_map.vh"

module pdo_mapper_asserts (
	// Clock and reset.
	input wire clk_in,
	input wire nrst_in,
	// Receive side.
	input wire [6:0] node_id_in,
	input wire rx_valid_in,
	input wire [10:0] rx_id_in,
	input wire [3:0] rx_dlc_in,
	input wire [63:0] rx_data_in,
	input wire sdo_wr_in,
	input wire sdo_refuse_out,
	// Transmit side.
	input wire tx_valid_out,
	input wire [10:0] tx_id_out,
	input wire [3:0] tx_dlc_out,
	input wire [63:0] tx_data_out,
	input wire tx_ready_in,
	// Applied values.
	input wire [15:0] pos_demand_out,
	input wire sync_seen_out,
	input wire [31:0] trk_alarm_lim_out,
	input wire [31:0] trk_shut_lim_out,
	input wire [1:0] diff_mode_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	// ============================================================
	// Decoded receive events.
	wire [10:0] nd = {4'h0, node_id_in};
	wire sync_rx = rx_valid_in && rx_id_in == `ID_SYNC;
	wire trk_rx = rx_valid_in && rx_id_in == `ID_RX_TRK_LIM + nd &&
		rx_dlc_in == `DLC_SLOW;
	wire dm_rx = rx_valid_in && rx_id_in == `ID_RX_DIFF_MODE + nd &&
		rx_dlc_in == `DLC_RX_DIFF_MODE && rx_data_in[15:0] <= `DMODE_AVG;

	// ============================================================
	// Properties; the causal ones tie an output to its cause with the exact delay, except a_fast_out, which allows 1 to 2 cycles.
	property p_sdo_ans; sdo_wr_in |=> sdo_refuse_out; endproperty
	a_sdo_ans: assert property (p_sdo_ans)
		else $error("SDO write not refused");
	property p_sdo_only; sdo_refuse_out |-> $past(sdo_wr_in); endproperty
	a_sdo_only: assert property (p_sdo_only)
		else $error("refusal without a write");
	property p_sync_seen; sync_rx |=> sync_seen_out; endproperty
	a_sync_seen: assert property (p_sync_seen)
		else $error("SYNC not flagged");
	property p_fast_out; sync_rx |-> ##[1:2] tx_valid_out; endproperty
	a_fast_out: assert property (p_fast_out)
		else $error("no status frame after SYNC");
	property p_fast_fmt;
		tx_valid_out && tx_id_out == `ID_TX_FAST + nd |->
			tx_dlc_out == `DLC_TX_FAST && tx_data_out[63:38] == 26'h0;
	endproperty
	a_fast_fmt: assert property (p_fast_fmt)
		else $error("status frame format wrong");
	property p_err_b;
		tx_valid_out && tx_id_out == `ID_TX_ERR_B + nd |->
			tx_dlc_out == `DLC_SLOW && tx_data_out[63:48] == 16'h0;
	endproperty
	a_err_b: assert property (p_err_b)
		else $error("second flag frame tail not zero");
	property p_err_c;
		tx_valid_out && tx_id_out == `ID_TX_ERR_C + nd |->
			tx_dlc_out == `DLC_SLOW && tx_data_out[63:48] == 16'h0;
	endproperty
	a_err_c: assert property (p_err_c)
		else $error("third flag frame tail not zero");
	property p_hold;
		tx_valid_out && !tx_ready_in |=> tx_valid_out &&
			$stable(tx_id_out) && $stable(tx_data_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("transmit head changed while stalled");
	property p_demand; $changed(pos_demand_out) |-> $past(sync_rx); endproperty
	a_demand: assert property (p_demand)
		else $error("demand applied without SYNC");
	property p_trk;
		trk_rx |=> {trk_shut_lim_out, trk_alarm_lim_out} == $past(rx_data_in);
	endproperty
	a_trk: assert property (p_trk)
		else $error("tracking limits not taken");
	property p_dmode; dm_rx |=> diff_mode_out == $past(rx_data_in[1:0]);
	endproperty
	a_dmode: assert property (p_dmode)
		else $error("difference mode not taken");

	// ============================================================
	// Main scenarios reached.
	c_sync: cover property (sync_rx);
	c_sdo: cover property (sdo_refuse_out);
	c_err_c: cover property (tx_valid_out && tx_id_out == `ID_TX_ERR_C + nd);
endmodule // pdo_mapper_asserts

// ===== sim/master_model.sv
// Behavioural network master facing the process-data layer.
// Assumes the bench calls its tasks and steers its transmit acceptance.
`timescale 1ns/10ps

module master_model (
	// Clock and steering from the bench.
	input wire clk_in,
	input wire hold_in,
	input wire slow_in,
	// Frames toward the block.
	output reg rx_valid_out,
	output reg [10:0] rx_id_out,
	output reg [3:0] rx_dlc_out,
	output reg [63:0] rx_data_out,
	output reg sdo_wr_out,
	// Frames from the block.
	input wire tx_valid_in,
	input wire [10:0] tx_id_in,
	input wire [3:0] tx_dlc_in,
	input wire [63:0] tx_data_in,
	output reg tx_ready_out
);
	logic [78:0] q[$];
	int stamp[$];
	int cyc = 0;
	logic ph = 1'b0;

	// Idle lines at start.
	initial begin
		rx_valid_out = 1'b0;
		rx_id_out = 11'h7FF;
		rx_dlc_out = 4'hF;
		rx_data_out = 64'h0;
		sdo_wr_out = 1'b0;
		tx_ready_out = 1'b1;
	end

	// One frame; released lines show the inverse so stale data never matches.
	task send(input logic [10:0] id, input logic [3:0] dlc,
		input logic [63:0] d);
		@(posedge clk_in);
		#1;
		rx_valid_out = 1'b1;
		rx_id_out = id;
		rx_dlc_out = dlc;
		rx_data_out = d;
		@(posedge clk_in);
		#1;
		rx_valid_out = 1'b0;
		rx_id_out = ~id;
		rx_dlc_out = ~dlc;
		rx_data_out = ~d;
	endtask

	// Single SDO write; the bench issues at most one per frame.
	task sdo();
		@(posedge clk_in);
		#1;
		sdo_wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		sdo_wr_out = 1'b0;
	endtask

	// Demands go out before SYNC, one of each per frame.
	task frame(input logic [10:0] id, input logic [3:0] dlc,
		input logic [63:0] d);
		send(id, dlc, d);
		send(11'h080, 4'h0, 64'h0);
	endtask

	// Collect taken frames; stall fully or every other cycle on request.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (tx_valid_in && tx_ready_out) begin
			q.push_back({tx_id_in, tx_dlc_in, tx_data_in});
			stamp.push_back(cyc);
		end
		ph <= ~ph;
		tx_ready_out <= #1 !hold_in && (!slow_in || ph);
	end
endmodule // master_model

// ===== sim/pdo_mapper_tb.sv
// Self-checking bench for the process-data layer with a master model.
// Assumes rtl/ is on the include path; slow tick shortened to TICK.
`timescale 1ns/10ps
`include "pdo_map.vh"

module pdo_mapper_tb;
	localparam int TICK = 20;
	localparam logic [10:0] N = 11'h005;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic hold = 1'b0;
	logic slow_rdy = 1'b0;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	wire rx_valid_in, sdo_wr_in, tx_ready_in, rx_ready_out, sdo_refuse_out;
	wire tx_valid_out, auto_detect_out, sync_seen_out;
	wire [10:0] rx_id_in, tx_id_out;
	wire [3:0] rx_dlc_in, tx_dlc_out;
	wire [63:0] rx_data_in, tx_data_out;
	wire [15:0] pos_demand_out, trk_alarm_time_out, trk_shut_time_out;
	wire [15:0] mot_alarm_time_out, mot_shut_time_out;
	wire [15:0] shf_alarm_time_out, shf_shut_time_out;
	wire [7:0] cmd1_out;
	wire [1:0] diff_mode_out;
	wire [31:0] trk_alarm_lim_out, trk_shut_lim_out, res_alarm_lim_out;
	wire [31:0] res_shut_lim_out, mot_alarm_lim_out, mot_shut_lim_out;
	wire [31:0] shf_alarm_lim_out, shf_shut_lim_out;
	logic [6:0] node_id_in = 7'h05;
	logic [15:0] act_pos_in = 16'h1234;
	logic [15:0] act_cur_in = 16'hABCD;
	logic [5:0] status_bits_in = 6'h2D;
	logic [31:0] drv_temp_in = 32'h41C8_0000;
	logic [31:0] drv_icur_in = 32'h3FC0_0000;
	logic [31:0] volt1_in = 32'h41C0_0000;
	logic [31:0] volt2_in = 32'h4150_0000;
	logic [223:0] err_flags_in = 224'h0;

	// ============================================================
	// Clock, design and partner.
	always #2.5 clk_in = ~clk_in;
	pdo_mapper #(.SLOW_TICK_CYCLES(TICK), .TICK_CW(5)) dut (.*);
	master_model m (.clk_in(clk_in), .hold_in(hold), .slow_in(slow_rdy),
		.rx_valid_out(rx_valid_in), .rx_id_out(rx_id_in),
		.rx_dlc_out(rx_dlc_in), .rx_data_out(rx_data_in),
		.sdo_wr_out(sdo_wr_in), .tx_valid_in(tx_valid_out),
		.tx_id_in(tx_id_out), .tx_dlc_in(tx_dlc_out),
		.tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));

	// ============================================================
	// Shared helpers.
	function automatic logic [15:0] ew(input int n);
		return 16'hC000 + 16'(n) * 16'h0111;
	endfunction
	task chk(input logic [78:0] got, input logic [78:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Bounded wait, since a lost frame must not hang the run.
	task wait_q(input int n);
		for (int i = 0; i < 300 && m.q.size() < n; i++) tick(1);
	endtask
	task summarize();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ============================================================
	// Scenarios.
	task test_sdo();
		m.sdo();
		chk(sdo_refuse_out, 1);
		tick(1);
		chk(sdo_refuse_out, 0);
		$display("test sdo done");
	endtask
	task test_fast();
		m.q.delete();
		m.send(`ID_RX_FAST + N, 4'h4, {32'h0, 8'h01, 8'h5A, 16'hBEEF});
		tick(2);
		chk(pos_demand_out, 0);
		chk(rx_ready_out, 1);
		m.send(`ID_SYNC, 4'h0, 64'h0);
		tick(2);
		chk({auto_detect_out, cmd1_out, pos_demand_out}, 25'h15ABEEF);
		wait_q(1);
		tick(10);
		chk(m.q.size(), 1);
		chk(m.q[0], {`ID_TX_FAST + N, 4'h5, 26'h0, 6'h2D, 32'hABCD1234});
		// Short demand keeps the previous second command byte.
		m.frame(`ID_RX_FAST + N, 4'h3, {40'h0, 8'hA5, 16'h0102});
		tick(2);
		chk({auto_detect_out, cmd1_out, pos_demand_out}, 25'h1A50102);
		$display("test fast done");
	endtask
	task test_params();
		logic [78:0] e[5];
		e[0] = {`ID_TX_TEMP + N, 4'h8, drv_icur_in, drv_temp_in};
		e[1] = {`ID_TX_VOLT + N, 4'h8, volt2_in, volt1_in};
		e[2] = {`ID_TX_ERR_A + N, 4'h8, ew(3), ew(2), ew(1), ew(0)};
		e[3] = {`ID_TX_ERR_B + N, 4'h8, 16'h0, ew(13), ew(5), ew(4)};
		e[4] = {`ID_TX_ERR_C + N, 4'h8, 16'h0, ew(10), ew(9), ew(8)};
		m.q.delete();
		m.stamp.delete();
		m.send(`ID_RX_TRK_LIM + N + 11'h1, 4'h8, 64'h5555_5555_5555_5555);
		tick(2);
		chk(trk_alarm_lim_out, 0);
		m.send(`ID_RX_TRK_LIM + N, 4'h8, 64'h4120_0000_3F80_0000);
		m.send(`ID_RX_RES_LIM + N, 4'h8, 64'h4248_0000_4000_0000);
		m.send(`ID_RX_TRK_TIME + N, 4'h4, 64'h0000_0000_2710_03E8);
		m.send(`ID_RX_MOT_LIM + N, 4'h8, 64'h42DC_0000_42C8_0000);
		m.send(`ID_RX_SHF_LIM + N, 4'h8, 64'h42B4_0000_42A0_0000);
		m.send(`ID_RX_PE_TIME + N, 4'h8, 64'h4444_3333_2222_1111);
		tick(2);
		chk({trk_shut_lim_out, trk_alarm_lim_out}, 64'h41200000_3F800000);
		chk({res_shut_lim_out, res_alarm_lim_out}, 64'h42480000_40000000);
		chk({trk_shut_time_out, trk_alarm_time_out}, 32'h2710_03E8);
		chk({mot_shut_lim_out, mot_alarm_lim_out}, 64'h42DC0000_42C80000);
		chk({shf_shut_lim_out, shf_alarm_lim_out}, 64'h42B40000_42A00000);
		chk({shf_shut_time_out, shf_alarm_time_out, mot_shut_time_out,
			mot_alarm_time_out}, 64'h4444_3333_2222_1111);
		wait_q(5);
		tick(3 * TICK);
		chk(m.q.size(), 5);
		for (int i = 0; i < 5; i++) begin
			chk(m.q[i], e[i]);
			if (i > 0) chk(m.stamp[i] - m.stamp[i - 1], TICK);
		end
		$display("test params done");
	endtask
	task test_dmode();
		for (int k = 0; k < 4; k++) begin
			m.send(`ID_RX_DIFF_MODE + N, 4'h2, 64'(k));
			tick(2);
			chk(diff_mode_out, (k > 2) ? 2 : k);
		end
		$display("test dmode done");
	endtask
	// Sixteen frames fill the buffer, one more waits, the last collapses.
	task test_fifo();
		m.q.delete();
		hold = 1'b1;
		repeat (18) begin
			m.send(`ID_SYNC, 4'h0, 64'h0);
			tick(2);
		end
		chk(tx_valid_out, 1);
		slow_rdy = 1'b1;
		hold = 1'b0;
		wait_q(17);
		tick(40);
		chk(m.q.size(), 17);
		chk(tx_valid_out, 0);
		for (int i = 0; i < 17; i++) chk(m.q[i][78:64], {`ID_TX_FAST + N, 4'h5});
		slow_rdy = 1'b0;
		$display("test fifo done");
	endtask

	// ============================================================
	// Hang guard: the whole run needs well under this many cycles.
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			summarize();
		end
	end

	// Main sequence.
	initial begin
		for (int n = 0; n < 14; n++) err_flags_in[16 * n +: 16] = ew(n);
		repeat (12) @(posedge clk_in);
		#1;
		nrst_in = 1'b1;
		tick(2);
		test_sdo();
		test_fast();
		test_params();
		test_dmode();
		test_fifo();
		summarize();
	end
endmodule // pdo_mapper_tb

bind pdo_mapper pdo_mapper_asserts chk (.*);
